// file: core/lvc_pin_config.sv
// Contract
// - First pin flips polarity in coded slot
// - First pin code 11: host controls only; a sequence start also returns it to its default level
// - Config one bit 2 enables first high-side
// - Config one bit 3 enables first low-side
// - First pull field selects pull arrangement
// - Bit 6 sets first pin default level
// - Bit 7 sets second pin default level
// - Second pin flips polarity in coded slot
// - Second pin code 11: host controls only; a sequence start also returns it to its default level
// - Config two bit 2 enables second high-side
// - Config two bit 3 enables second low-side
// - Config two bits 4-5 select second pull
// - Config two bits 6-7 select input pull
// - All fields clear on power-on reset
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "lvc_defs.svh"

module lvc_pin_config (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic seq_start,
    input wire logic [2:0] slot_strobe,
    input wire logic host_write,
    input wire logic [1:0] host_level,
    output lvc_pkg::lvc_slot_t first_pin_slot_select,
    output lvc_pkg::lvc_slot_t second_pin_slot_select,
    output lvc_pkg::lvc_drive_s lv_io_first,
    output lvc_pkg::lvc_drive_s lv_io_second,
    output lvc_pkg::lvc_pull_s lv_input_only_pin
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic lvc_pkg::lvc_pull_s pull_decode(input logic [1:0] code);
        lvc_pkg::lvc_pull_s p;
        p = '0;
        case (lvc_pkg::lvc_pull_e'(code))
            lvc_pkg::LVC_PULL_REPEATER: begin
                p.repeater = 1'b1;
            end
            lvc_pkg::LVC_PULL_DOWN_ONLY: begin
                p.pull_down = 1'b1;
            end
            lvc_pkg::LVC_PULL_UP_ONLY: begin
                p.pull_up = 1'b1;
            end
            default: begin
                p = '0;
            end
        endcase
        return p;
    endfunction : pull_decode

    // Code 11 never matches a slot, so a host-owned pin ignores the slot strobes
    function automatic logic slot_hit(input logic [1:0] code, input logic [2:0] strobe);
        logic hit;
        hit = 1'b0;
        if (code != `LVC_SLOT_HOST) begin
            hit = strobe[code];
        end
        return hit;
    endfunction : slot_hit

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    lvc_pkg::lvc_state_s state_reg;
    lvc_pkg::lvc_state_s state_next;
    logic [7:0] cfg_pin [2];
    logic [1:0] dflt_level;
    logic [1:0] pin_level;
    lvc_pkg::lvc_drive_s drive [2];

    assign cfg_pin[0] = state_reg.cfg_first;
    assign cfg_pin[1] = state_reg.cfg_second;
    assign dflt_level[0] = state_reg.cfg_first[`LVC_FIRST_DFLT_BIT];
    assign dflt_level[1] = state_reg.cfg_first[`LVC_SECOND_DFLT_BIT];

    always_comb begin
        state_next = state_reg;
        state_next.rdata = `LVC_RDATA_RESET;
        if (wr) begin
            case (addr)
                `LVC_ADDR_CFG_FIRST: begin
                    state_next.cfg_first = wdata;
                end
                `LVC_ADDR_CFG_SECOND: begin
                    state_next.cfg_second = wdata;
                end
                default: begin
                    state_next.cfg_first = state_reg.cfg_first;
                end
            endcase
        end
        if (rd) begin
            case (addr)
                `LVC_ADDR_CFG_FIRST: begin
                    state_next.rdata = state_reg.cfg_first;
                end
                `LVC_ADDR_CFG_SECOND: begin
                    state_next.rdata = state_reg.cfg_second;
                end
                default: begin
                    state_next.rdata = `LVC_RDATA_RESET;
                end
            endcase
        end
        // A new sequence returns every pin to its default level; a slot reached,
        // or a host command to a host-owned pin, in the same cycle still wins so the event is not lost
        if (seq_start) begin
            state_next.released = `LVC_RELEASED_RESET;
        end
        for (int i = 0; i < 2; i++) begin
            if (cfg_pin[i][1:0] == `LVC_SLOT_HOST) begin
                if (host_write) begin
                    state_next.released[i] = host_level[i];
                end
            end else if (slot_hit(cfg_pin[i][1:0], slot_strobe)) begin
                state_next.released[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg.cfg_first <= `LVC_CFG_RESET;
            state_reg.cfg_second <= `LVC_CFG_RESET;
            state_reg.released <= `LVC_RELEASED_RESET;
            state_reg.rdata <= `LVC_RDATA_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive decode
    // ----------------------------------------------------------------
    // The level is the default flipped once released; only the driver that
    // matches the level is switched on, and only if it is enabled
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            assign pin_level[g] = dflt_level[g] ^ state_reg.released[g];
            assign drive[g].high_side_driver = pin_level[g] & cfg_pin[g][`LVC_HS_BIT];
            assign drive[g].low_side_driver = ~pin_level[g] & cfg_pin[g][`LVC_LS_BIT];
            assign drive[g].pin_out = pin_level[g];
            assign drive[g].pin_oe = drive[g].high_side_driver | drive[g].low_side_driver;
            assign drive[g].pull = pull_decode(cfg_pin[g][`LVC_PULL_LSB +: 2]);
        end
    endgenerate

    assign lv_io_first = drive[0];
    assign lv_io_second = drive[1];
    // Pull-up is what a serial data input wants; software must program it
    assign lv_input_only_pin = pull_decode(state_reg.cfg_second[`LVC_INPUT_PULL_LSB +: 2]);
    assign first_pin_slot_select = state_reg.cfg_first[`LVC_SLOT_LSB +: 2];
    assign second_pin_slot_select = state_reg.cfg_second[`LVC_SLOT_LSB +: 2];
    assign rdata = state_reg.rdata;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    first_slot_release_a: assert property (
        !wr && first_pin_slot_select != `LVC_SLOT_HOST
        && slot_strobe[first_pin_slot_select]
        |=> lv_io_first.pin_out == !cfg_pin[0][`LVC_FIRST_DFLT_BIT])
        else $error("first pin did not flip in its slot");

    first_host_hold_a: assert property (
        !wr && first_pin_slot_select == `LVC_SLOT_HOST && !host_write && !seq_start
        |=> $stable(state_reg.released[0]))
        else $error("host-owned first pin changed without host");

    first_high_side_a: assert property (
        lv_io_first.high_side_driver |-> state_reg.cfg_first[`LVC_HS_BIT]
        && lv_io_first.pin_out)
        else $error("first high-side on while disabled");

    first_low_side_a: assert property (
        !lv_io_first.pin_out && state_reg.cfg_first[`LVC_LS_BIT]
        |-> lv_io_first.low_side_driver && lv_io_first.pin_oe)
        else $error("first low-side not driving low level");

    first_pull_a: assert property (
        (state_reg.cfg_first[5:4] == 2'h1) |-> lv_io_first.pull == 3'h2)
        else $error("first pin pull-down code decoded wrong");

    first_default_a: assert property (
        seq_start && !wr && slot_strobe == 3'h0
        && (!host_write || first_pin_slot_select != `LVC_SLOT_HOST)
        |=> lv_io_first.pin_out == cfg_pin[0][`LVC_FIRST_DFLT_BIT])
        else $error("first pin not at default after sequence start");

    second_default_a: assert property (
        seq_start && !wr && slot_strobe == 3'h0
        && (!host_write || second_pin_slot_select != `LVC_SLOT_HOST)
        |=> lv_io_second.pin_out == cfg_pin[0][`LVC_SECOND_DFLT_BIT])
        else $error("second pin not at default after sequence start");

    second_slot_release_a: assert property (
        !wr && second_pin_slot_select != `LVC_SLOT_HOST
        && slot_strobe[second_pin_slot_select]
        |=> state_reg.released[1])
        else $error("second pin did not flip in its slot");

    second_host_only_a: assert property (
        !wr && second_pin_slot_select == `LVC_SLOT_HOST && host_write
        |=> state_reg.released[1] == $past(host_level[1]))
        else $error("second pin ignored host command");

    second_high_side_a: assert property (
        !state_reg.cfg_second[`LVC_HS_BIT] |-> !lv_io_second.high_side_driver)
        else $error("second high-side on while disabled");

    second_low_side_a: assert property (
        !state_reg.cfg_second[`LVC_LS_BIT] |-> !lv_io_second.low_side_driver)
        else $error("second low-side on while disabled");

    second_pull_a: assert property (
        (state_reg.cfg_second[5:4] == 2'h3) |-> lv_io_second.pull == 3'h0)
        else $error("second pin no-pull code decoded wrong");

    input_pull_a: assert property (
        (state_reg.cfg_second[7:6] == 2'h2) |-> lv_input_only_pin == 3'h1)
        else $error("input pin pull-up code decoded wrong");

    reset_clear_a: assert property (
        !$past(rstn) |-> state_reg.cfg_first == 8'h00
        && state_reg.cfg_second == 8'h00 && rdata == 8'h00)
        else $error("configuration not clear after reset");

    slot_present_a: assert property (
        wr && addr == `LVC_ADDR_CFG_SECOND
        |=> second_pin_slot_select == $past(wdata[1:0]))
        else $error("slot code not presented to sequencer");

    read_timing_a: assert property (
        rd && addr == `LVC_ADDR_CFG_FIRST
        |=> rdata == $past(state_reg.cfg_first) ##1 ($past(rd) || rdata == 8'h00))
        else $error("read data not for exactly one cycle");

    first_pull_up_a: assert property (
        state_reg.cfg_first[`LVC_PULL_LSB +: 2] == 2'h2
        |-> lv_io_first.pull == 3'h1)
        else $error("first pin pull-up code decoded wrong");

    first_no_pull_a: assert property (
        state_reg.cfg_first[`LVC_PULL_LSB +: 2] == 2'h3
        |-> lv_io_first.pull == 3'h0)
        else $error("first pin no-pull code decoded wrong");

    first_repeater_a: assert property (
        state_reg.cfg_first[`LVC_PULL_LSB +: 2] == 2'h0
        |-> lv_io_first.pull == 3'h4)
        else $error("first pin repeater code decoded wrong");

    second_pull_down_a: assert property (
        state_reg.cfg_second[`LVC_PULL_LSB +: 2] == 2'h1
        |-> lv_io_second.pull == 3'h2)
        else $error("second pin pull-down code decoded wrong");

    second_pull_up_a: assert property (
        state_reg.cfg_second[`LVC_PULL_LSB +: 2] == 2'h2
        |-> lv_io_second.pull == 3'h1)
        else $error("second pin pull-up code decoded wrong");

    second_repeater_a: assert property (
        state_reg.cfg_second[`LVC_PULL_LSB +: 2] == 2'h0
        |-> lv_io_second.pull == 3'h4)
        else $error("second pin repeater code decoded wrong");

    input_pull_down_a: assert property (
        state_reg.cfg_second[`LVC_INPUT_PULL_LSB +: 2] == 2'h1
        |-> lv_input_only_pin == 3'h2)
        else $error("input pin pull-down code decoded wrong");

    input_no_pull_a: assert property (
        state_reg.cfg_second[`LVC_INPUT_PULL_LSB +: 2] == 2'h3
        |-> lv_input_only_pin == 3'h0)
        else $error("input pin no-pull code decoded wrong");

    first_hs_drive_a: assert property (
        state_reg.cfg_first[`LVC_HS_BIT] && lv_io_first.pin_out
        |-> lv_io_first.high_side_driver && lv_io_first.pin_oe)
        else $error("first high-side not driving high level");

    first_ls_off_a: assert property (
        !state_reg.cfg_first[`LVC_LS_BIT]
        |-> !lv_io_first.low_side_driver)
        else $error("first low-side on while disabled");

    second_hs_drive_a: assert property (
        state_reg.cfg_second[`LVC_HS_BIT] && lv_io_second.pin_out
        |-> lv_io_second.high_side_driver && lv_io_second.pin_oe)
        else $error("second high-side not driving high level");

    second_ls_drive_a: assert property (
        state_reg.cfg_second[`LVC_LS_BIT] && !lv_io_second.pin_out
        |-> lv_io_second.low_side_driver && lv_io_second.pin_oe)
        else $error("second low-side not driving low level");

    second_slot_level_a: assert property (
        !wr && second_pin_slot_select != `LVC_SLOT_HOST
        && slot_strobe[second_pin_slot_select]
        |=> lv_io_second.pin_out == !state_reg.cfg_first[`LVC_SECOND_DFLT_BIT])
        else $error("second pin level not flipped in its slot");

    first_host_level_a: assert property (
        !wr && first_pin_slot_select == `LVC_SLOT_HOST && host_write
        |=> state_reg.released[0] == $past(host_level[0]))
        else $error("first pin ignored host command");

    second_host_hold_a: assert property (
        !wr && second_pin_slot_select == `LVC_SLOT_HOST && !host_write && !seq_start
        |=> $stable(state_reg.released[1]))
        else $error("host-owned second pin changed without host");

    first_slot_present_a: assert property (
        wr && addr == `LVC_ADDR_CFG_FIRST
        |=> first_pin_slot_select == $past(wdata[1:0]))
        else $error("first slot code not presented to sequencer");

    slot_release_c: cover property (
        first_pin_slot_select == 2'h2 && slot_strobe[2] ##1 state_reg.released[0]);
    host_control_c: cover property (
        second_pin_slot_select == `LVC_SLOT_HOST && host_write && host_level[1]);
    write_read_c: cover property (
        wr && addr == `LVC_ADDR_CFG_FIRST ##1 rd && addr == `LVC_ADDR_CFG_FIRST);
    restart_c: cover property (state_reg.released[0] && seq_start);
    host_restart_c: cover property (
        first_pin_slot_select == `LVC_SLOT_HOST && host_write && seq_start);

endmodule : lvc_pin_config

// file: inc/lvc_defs.svh
`ifndef LVC_DEFS_SVH
`define LVC_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define LVC_ADDR_W 4
`define LVC_ADDR_CFG_FIRST 4'h0
`define LVC_ADDR_CFG_SECOND 4'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LVC_SLOT_LSB 0
`define LVC_HS_BIT 2
`define LVC_LS_BIT 3
`define LVC_PULL_LSB 4
`define LVC_FIRST_DFLT_BIT 6
`define LVC_SECOND_DFLT_BIT 7
`define LVC_INPUT_PULL_LSB 6

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define LVC_CFG_RESET 8'h00
`define LVC_RELEASED_RESET 2'h0
`define LVC_RDATA_RESET 8'h00
`define LVC_SLOT_HOST 2'h3

`endif

// file: inc/lvc_pkg.sv
package lvc_pkg;

    // ----------------------------------------------------------------
    // Pull selection codes, shared by all three pins
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LVC_PULL_REPEATER = 2'h0,
        LVC_PULL_DOWN_ONLY = 2'h1,
        LVC_PULL_UP_ONLY = 2'h2,
        LVC_PULL_NONE = 2'h3
    } lvc_pull_e;

    typedef logic [1:0] lvc_slot_t;

    typedef struct packed {
        logic repeater;
        logic pull_down;
        logic pull_up;
    } lvc_pull_s;

    typedef struct packed {
        logic high_side_driver;
        logic low_side_driver;
        logic pin_out;
        logic pin_oe;
        lvc_pull_s pull;
    } lvc_drive_s;

    typedef struct packed {
        logic [7:0] cfg_first;
        logic [7:0] cfg_second;
        logic [1:0] released;
        logic [7:0] rdata;
    } lvc_state_s;

endpackage : lvc_pkg

// file: testbench/lvc_pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// External load on one low-voltage I/O
// ----------------------------------------------------------------
module lvc_pin_model #(
    parameter logic EXT_PULL_HIGH = 1'b1
) (
    input wire lvc_pkg::lvc_drive_s drive,
    output logic level
);
    // An undriven pin settles to the external pull, never to its last level
    always_comb begin
        if (drive.high_side_driver) begin
            level = 1'b1;
        end else if (drive.low_side_driver) begin
            level = 1'b0;
        end else begin
            level = EXT_PULL_HIGH;
        end
    end
endmodule : lvc_pin_model

// file: testbench/tb_lvc_pin_config.sv
`timescale 1ns/100ps
`include "lvc_defs.svh"
module tb_lvc_pin_config;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic seq_start = 1'b0;
    logic [2:0] slot_strobe = 3'h0;
    logic host_write = 1'b0;
    logic [1:0] host_level = 2'h0;
    lvc_pkg::lvc_slot_t slot1;
    lvc_pkg::lvc_slot_t slot2;
    lvc_pkg::lvc_drive_s io1;
    lvc_pkg::lvc_drive_s io2;
    lvc_pkg::lvc_pull_s in_pull;
    logic lvl1;
    logic lvl2;
    logic [7:0] cfg1 = 8'h00;
    logic [7:0] cfg2 = 8'h00;
    logic [1:0] rel = 2'h0;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    lvc_pin_config lvc_pin_config_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .seq_start(seq_start), .slot_strobe(slot_strobe),
        .host_write(host_write), .host_level(host_level), .first_pin_slot_select(slot1),
        .second_pin_slot_select(slot2), .lv_io_first(io1), .lv_io_second(io2),
        .lv_input_only_pin(in_pull));
    lvc_pin_model lvc_pin_model_inst (.drive(io1), .level(lvl1));
    // Second pin sees an external pull-down, so an idle pin must read low
    lvc_pin_model #(.EXT_PULL_HIGH(1'b0)) lvc_pin_model_pd_inst (.drive(io2), .level(lvl2));

    // ----------------------------------------------------------------
    // Reporting, compares and bus cycles
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done;
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_io(input lvc_pkg::lvc_drive_s got, input lvc_pkg::lvc_drive_s exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: pin drive %b, wanted %b", $time, got, exp);
        end
    endtask : chk_io

    function automatic lvc_pkg::lvc_drive_s exp_io(input logic lvl, input logic hs,
            input logic ls, input logic [1:0] pc);
        exp_io.pin_out = lvl;
        exp_io.high_side_driver = lvl & hs;
        exp_io.low_side_driver = ~lvl & ls;
        exp_io.pin_oe = (lvl & hs) | (~lvl & ls);
        exp_io.pull = {pc == 2'h0, pc == 2'h1, pc == 2'h2};
    endfunction : exp_io

    task automatic chk_pins;
        lvc_pkg::lvc_drive_s e;
        e = exp_io(cfg1[6] ^ rel[0], cfg1[2], cfg1[3], cfg1[5:4]);
        chk_io(io1, e);
        chk8({7'h0, lvl1}, {7'h0, e.high_side_driver | ~e.low_side_driver});
        e = exp_io(cfg1[7] ^ rel[1], cfg2[2], cfg2[3], cfg2[5:4]);
        chk_io(io2, e);
        chk8({7'h0, lvl2}, {7'h0, e.high_side_driver});
        e = exp_io(1'b0, 1'b0, 1'b0, cfg2[7:6]);
        chk8({5'h0, in_pull}, {5'h0, e.pull});
        chk8({4'h0, slot1, slot2}, {4'h0, cfg1[1:0], cfg2[1:0]});
    endtask : chk_pins

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        if (a == `LVC_ADDR_CFG_FIRST) cfg1 = d;
        if (a == `LVC_ADDR_CFG_SECOND) cfg2 = d;
        @(negedge clk);
        chk_pins;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk8(rdata, exp);
    endtask : rd_chk

    // Mirrors the released flags: a strobe or host command beats a start
    task automatic seq(input logic st, input logic [2:0] sb, input logic hw, input logic [1:0] hl);
        logic [1:0] c;
        @(posedge clk);
        seq_start <= st;
        slot_strobe <= sb;
        host_write <= hw;
        host_level <= hl;
        @(posedge clk);
        seq_start <= 1'b0;
        slot_strobe <= 3'h0;
        host_write <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            c = i ? cfg2[1:0] : cfg1[1:0];
            if (c == `LVC_SLOT_HOST && hw) rel[i] = hl[i];
            else if (c != `LVC_SLOT_HOST && sb[c]) rel[i] = 1'b1;
            else if (st) rel[i] = 1'b0;
        end
        @(negedge clk);
        chk_pins;
    endtask : seq

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_fields;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr_reg(`LVC_ADDR_CFG_FIRST, {c, c, c[0], c[1], 2'h3});
            wr_reg(`LVC_ADDR_CFG_SECOND, {c, ~c, c[1], c[0], 2'h3});
            rd_chk(`LVC_ADDR_CFG_FIRST, cfg1);
            rd_chk(`LVC_ADDR_CFG_SECOND, cfg2);
        end
        wr_reg(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00);
        rd_chk(`LVC_ADDR_CFG_FIRST, cfg1);
    endtask : t_fields

    task automatic t_slots;
        logic [1:0] c;
        for (int i = 0; i < 3; i++) begin
            c = i[1:0];
            wr_reg(`LVC_ADDR_CFG_FIRST, {2'h1, 2'h2, 2'h3, c});
            wr_reg(`LVC_ADDR_CFG_SECOND, {2'h2, 2'h1, 2'h3, 2'h2 - c});
            seq(1'b1, 3'h0, 1'b0, 2'h0);
            for (int k = 0; k < 3; k++) begin
                seq(1'b0, 3'h1 << k, 1'b1, 2'h3);
            end
            seq(1'b1, 3'h1 << c, 1'b0, 2'h0);
            seq(1'b1, 3'h0, 1'b0, 2'h0);
        end
    endtask : t_slots

    task automatic t_host;
        wr_reg(`LVC_ADDR_CFG_FIRST, {2'h2, 2'h3, 2'h3, `LVC_SLOT_HOST});
        wr_reg(`LVC_ADDR_CFG_SECOND, {2'h1, 2'h0, 2'h3, `LVC_SLOT_HOST});
        seq(1'b0, 3'h7, 1'b0, 2'h0);
        seq(1'b0, 3'h0, 1'b1, 2'h2);
        seq(1'b0, 3'h0, 1'b1, 2'h1);
        wr_reg(`LVC_ADDR_CFG_SECOND, {2'h1, 2'h0, 2'h3, 2'h0});
        seq(1'b1, 3'h0, 1'b1, 2'h3);
        seq(1'b0, 3'h1, 1'b1, 2'h0);
    endtask : t_host

    task automatic t_midreset;
        @(posedge clk);
        rstn <= 1'b0;
        cfg1 = 8'h00;
        cfg2 = 8'h00;
        rel = 2'h0;
        @(negedge clk);
        chk_pins;
        chk8(rdata, 8'h00);
        @(posedge clk);
        rstn <= 1'b1;
        rd_chk(`LVC_ADDR_CFG_FIRST, 8'h00);
        rd_chk(`LVC_ADDR_CFG_SECOND, 8'h00);
    endtask : t_midreset

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_midreset;
        t_fields;
        t_slots;
        t_host;
        t_midreset;
        test_done;
    end
endmodule : tb_lvc_pin_config
